// ### dsp_ctrl_pkg.sv
package dsp_ctrl_pkg;
	// data-mapped register addresses
	localparam logic [15:0] ADDR_RX_DATA = 16'h0000;
	localparam logic [15:0] ADDR_TX_DATA = 16'h0001;
	localparam logic [15:0] ADDR_COUNT = 16'h0002;
	localparam logic [15:0] ADDR_PERIOD = 16'h0003;
	localparam logic [15:0] ADDR_MASK = 16'h0004;
	localparam logic [15:0] ADDR_SHARED = 16'h0005;
	// reset values
	localparam logic [15:0] COUNT_RESET = 16'hFFFF;
	localparam logic [15:0] PERIOD_RESET = 16'hFFFF;
	localparam logic [15:0] MASK_RESET = 16'h0000;
	localparam logic [7:0] SHARED_RESET = 8'h00;
	localparam logic [1:0] MAP_RESET = 2'h0;
	// interrupt mask bit positions, also priority order (low index wins)
	localparam int IRQ_EXT0 = 0;
	localparam int IRQ_EXT1 = 1;
	localparam int IRQ_EXT2 = 2;
	localparam int IRQ_TIMER = 3;
	localparam int IRQ_RX = 4;
	localparam int IRQ_TX = 5;
	localparam int IRQ_COUNT = 6;
	// vector slots: reset at 0, trap last, two words each
	localparam logic [15:0] VEC_RESET = 16'h0000;
	localparam logic [15:0] VEC_FIRST_IRQ = 16'h0002;
	localparam logic [15:0] VEC_TRAP = 16'h001E;
	localparam int VEC_STRIDE_SHIFT = 1;
	// auxiliary register update modes
	typedef enum logic [2:0] {
		AUX_NONE, AUX_INC, AUX_DEC, AUX_ADD_IDX, AUX_SUB_IDX, AUX_REV_INC, AUX_REV_DEC
	} aux_mode_t;
	// product shift modes
	typedef enum logic [1:0] {SHIFT_NONE, SHIFT_LEFT1, SHIFT_LEFT4, SHIFT_RIGHT6} prod_shift_t;
	localparam logic [7:0] REPEAT_RESET = 8'h00;
endpackage

// ### dsp_ctrl.sv
`timescale 1ns/1ns
module dsp_ctrl
	import dsp_ctrl_pkg::*;
(
	input wire logic SYS_CLK_I,
	input wire logic NRST_I,
	// multiplier
	input wire logic MUL_LOAD_OPERAND_I,
	input wire logic [15:0] MUL_OPERAND_I,
	input wire logic MUL_START_I,
	input wire logic [15:0] MUL_DATA_I,
	input wire logic MUL_UNSIGNED_I,
	input wire logic MUL_SET_SHIFT_I,
	input wire logic [1:0] MUL_SHIFT_I,
	output logic [31:0] PRODUCT_SHIFTED_O,
	// ram map select
	input wire logic MAP_SELECT_I,
	input wire logic [1:0] MAP_CODE_I,
	output logic [3:0] BLOCK_IS_PROGRAM_O,
	// data access from the core
	input wire logic ACC_REQ_I,
	input wire logic ACC_WRITE_I,
	input wire logic ACC_INDIRECT_I,
	input wire logic [6:0] ACC_OFFSET_I,
	input wire logic [15:0] ACC_WDATA_I,
	input wire logic [2:0] AUX_MODE_I,
	input wire logic [2:0] AUX_NEXT_PTR_I,
	input wire logic AUX_LOAD_I,
	input wire logic [15:0] AUX_LOAD_DATA_I,
	input wire logic PAGE_LOAD_I,
	input wire logic [8:0] PAGE_I,
	input wire logic [15:0] RX_DATA_I,
	input wire logic RX_DATA_LOAD_I,
	output logic [15:0] ACC_RDATA_O,
	output logic ACC_DONE_O,
	output logic ACC_EXTERNAL_O,
	output logic [15:0] DATA_ADDR_O,
	output logic [15:0] TX_DATA_O,
	// external bus
	input wire logic READY_I,
	input wire logic NHOLD_I,
	output logic NSHARED_BUS_REQUEST_O,
	output logic NEXTERNAL_BUS_GRANT_ACK_O,
	output logic BUS_OE_O,
	output logic [15:0] EXT_ADDR_O,
	// repeat and interrupts
	input wire logic REPEAT_LOAD_I,
	input wire logic [7:0] REPEAT_VALUE_I,
	input wire logic INSTR_DONE_I,
	input wire logic MULTICYCLE_I,
	input wire logic [2:0] NEXT_INTERRUPT_INPUTS_I,
	input wire logic RX_EVENT_I,
	input wire logic TX_EVENT_I,
	input wire logic TRAP_I,
	input wire logic IRQ_ACK_I,
	output logic REPEAT_ACTIVE_O,
	output logic SINGLE_CYCLE_REPEAT_O,
	output logic IRQ_TAKE_O,
	output logic [15:0] IRQ_VECTOR_O,
	output logic COUNTDOWN_INTERRUPT_O
);

	logic [15:0] multiplier_operand_reg;
	logic [31:0] multiplier_result_reg;
	logic [1:0] shift_mode_reg;
	logic [15:0] countdown_value_reg;
	logic [15:0] reload_period_reg;
	logic [15:0] interrupt_mask_reg;
	logic [7:0] shared_memory_size_reg;
	logic [15:0] serial_receive_data_reg;
	logic [15:0] serial_send_data_reg;
	logic [1:0] map_reg;
	logic [8:0] page_reg;
	logic [2:0] aux_pointer_select;
	logic [15:0] aux_address_regs [8];
	logic [7:0] repeat_count_reg;
	logic repeat_active_reg;
	logic [IRQ_COUNT-1:0] pending_reg;
	logic hold_ack_reg;
	logic [15:0] rdata_reg;
	logic [15:0] addr_reg;
	logic [2:0] ext_prev_reg;
	logic timer_zero;
	logic [15:0] addr_next;
	logic is_shared;
	logic is_mapped;
	logic acc_done;
	logic [IRQ_COUNT-1:0] irq_live;
	logic [15:0] vector_next;
	logic irq_any;

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic [15:0] bit_rev_step(input logic [15:0] a, input logic [15:0] idx,
		input logic dec);
		logic [15:0] ra;
		logic [15:0] ri;
		ra = {<<{a}};
		ri = {<<{idx}};
		return {<<{dec ? 16'(ra - ri) : 16'(ra + ri)}};
	endfunction

	function automatic logic [31:0] shift_product(input logic [31:0] p, input logic [1:0] m);
		case (m)
			2'd1: return {p[30:0], 1'b0};
			2'd2: return {p[27:0], 4'h0};
			2'd3: return {{6{p[31]}}, p[31:6]};
			default: return p;
		endcase
	endfunction

	// ------------------------------------------------------------
	// multiplier
	// ------------------------------------------------------------
	always_ff @(posedge SYS_CLK_I or negedge NRST_I)
	begin
		if (!NRST_I)
		begin
			multiplier_operand_reg <= 16'h0000;
			multiplier_result_reg <= 32'h0000_0000;
			shift_mode_reg <= 2'h0;
		end
		else
		begin
			if (MUL_LOAD_OPERAND_I)
				multiplier_operand_reg <= MUL_OPERAND_I;
			if (MUL_SET_SHIFT_I)
				shift_mode_reg <= MUL_SHIFT_I;
			if (MUL_START_I)
				multiplier_result_reg <= MUL_UNSIGNED_I ?
					{16'h0000, multiplier_operand_reg} * {16'h0000, MUL_DATA_I} :
					{{16{multiplier_operand_reg[15]}}, multiplier_operand_reg} *
					{{16{MUL_DATA_I[15]}}, MUL_DATA_I};
		end
	end

	always_ff @(posedge SYS_CLK_I or negedge NRST_I)
	begin
		if (!NRST_I)
			PRODUCT_SHIFTED_O <= 32'h0000_0000;
		else
			PRODUCT_SHIFTED_O <= shift_product(multiplier_result_reg, shift_mode_reg);
	end

	// ------------------------------------------------------------
	// addressing
	// ------------------------------------------------------------
	// page concat or current aux register
	assign addr_next = ACC_INDIRECT_I ? aux_address_regs[aux_pointer_select] :
		{page_reg, ACC_OFFSET_I};
	assign is_mapped = addr_next <= ADDR_SHARED;
	// shared region is the top size*256 words of data space
	assign is_shared = !is_mapped && (shared_memory_size_reg != 8'h00) &&
		(addr_next[15:8] >= 8'(8'h00 - shared_memory_size_reg));
	assign acc_done = ACC_REQ_I && (is_mapped || READY_I) && !hold_ack_reg;
	assign ACC_DONE_O = acc_done;
	assign ACC_EXTERNAL_O = ACC_REQ_I && !is_mapped;
	assign NSHARED_BUS_REQUEST_O = !(ACC_REQ_I && is_shared && !hold_ack_reg);
	assign DATA_ADDR_O = addr_reg;
	assign EXT_ADDR_O = addr_reg;

	always_ff @(posedge SYS_CLK_I or negedge NRST_I)
	begin
		if (!NRST_I)
		begin
			page_reg <= 9'h000;
			aux_pointer_select <= 3'h0;
			addr_reg <= 16'h0000;
			for (int i = 0; i < 8; i++)
				aux_address_regs[i] <= 16'h0000;
		end
		else
		begin
			if (PAGE_LOAD_I)
				page_reg <= PAGE_I;
			if (ACC_REQ_I)
				addr_reg <= addr_next;
			if (AUX_LOAD_I)
				aux_address_regs[aux_pointer_select] <= AUX_LOAD_DATA_I;
			else if (acc_done && ACC_INDIRECT_I)
			begin
				case (aux_mode_t'(AUX_MODE_I))
					AUX_INC: aux_address_regs[aux_pointer_select] <= 16'(addr_next + 16'h0001);
					AUX_DEC: aux_address_regs[aux_pointer_select] <= 16'(addr_next - 16'h0001);
					AUX_ADD_IDX: aux_address_regs[aux_pointer_select] <=
						16'(addr_next + aux_address_regs[0]);
					AUX_SUB_IDX: aux_address_regs[aux_pointer_select] <=
						16'(addr_next - aux_address_regs[0]);
					AUX_REV_INC: aux_address_regs[aux_pointer_select] <=
						bit_rev_step(addr_next, aux_address_regs[0], 1'b0);
					AUX_REV_DEC: aux_address_regs[aux_pointer_select] <=
						bit_rev_step(addr_next, aux_address_regs[0], 1'b1);
					default: ;
				endcase
				aux_pointer_select <= AUX_NEXT_PTR_I;
			end
		end
	end

	// ------------------------------------------------------------
	// mapped registers and timer
	// ------------------------------------------------------------
	// zero detect drives reload next cycle
	assign timer_zero = countdown_value_reg == 16'h0000;

	always_ff @(posedge SYS_CLK_I or negedge NRST_I)
	begin
		if (!NRST_I)
		begin
			countdown_value_reg <= COUNT_RESET;
			reload_period_reg <= PERIOD_RESET;
			interrupt_mask_reg <= MASK_RESET;
			shared_memory_size_reg <= SHARED_RESET;
			serial_receive_data_reg <= 16'h0000;
			serial_send_data_reg <= 16'h0000;
			rdata_reg <= 16'h0000;
		end
		else
		begin
			if (timer_zero)
				countdown_value_reg <= reload_period_reg;
			else
				countdown_value_reg <= 16'(countdown_value_reg - 16'h0001);
			if (RX_DATA_LOAD_I)
				serial_receive_data_reg <= RX_DATA_I;
			if (acc_done && is_mapped && ACC_WRITE_I)
			begin
				case (addr_next)
					ADDR_RX_DATA: serial_receive_data_reg <= ACC_WDATA_I;
					ADDR_TX_DATA: serial_send_data_reg <= ACC_WDATA_I;
					ADDR_COUNT: countdown_value_reg <= ACC_WDATA_I;
					ADDR_PERIOD: reload_period_reg <= ACC_WDATA_I;
					ADDR_MASK: interrupt_mask_reg <= ACC_WDATA_I;
					ADDR_SHARED: shared_memory_size_reg <= ACC_WDATA_I[7:0];
					default: ;
				endcase
			end
			if (acc_done && is_mapped && !ACC_WRITE_I)
			begin
				case (addr_next)
					ADDR_RX_DATA: rdata_reg <= serial_receive_data_reg;
					ADDR_TX_DATA: rdata_reg <= serial_send_data_reg;
					ADDR_COUNT: rdata_reg <= countdown_value_reg;
					ADDR_PERIOD: rdata_reg <= reload_period_reg;
					ADDR_MASK: rdata_reg <= interrupt_mask_reg;
					ADDR_SHARED: rdata_reg <= {8'h00, shared_memory_size_reg};
					default: rdata_reg <= 16'h0000;
				endcase
			end
		end
	end
	assign ACC_RDATA_O = rdata_reg;
	assign TX_DATA_O = serial_send_data_reg;

	// ------------------------------------------------------------
	// ram map
	// ------------------------------------------------------------
	// reset to all-data
	always_ff @(posedge SYS_CLK_I or negedge NRST_I)
	begin
		if (!NRST_I)
			map_reg <= MAP_RESET;
		else if (MAP_SELECT_I)
			map_reg <= MAP_CODE_I;
	end

	always_comb
	begin
		case (map_reg)
			2'd1: BLOCK_IS_PROGRAM_O = 4'b0001;
			2'd2: BLOCK_IS_PROGRAM_O = 4'b0011;
			2'd3: BLOCK_IS_PROGRAM_O = 4'b1011;
			default: BLOCK_IS_PROGRAM_O = 4'b0000;
		endcase
	end

	// ------------------------------------------------------------
	// hold and bus surrender
	// ------------------------------------------------------------
	// float bus, ack until hold released
	always_ff @(posedge SYS_CLK_I or negedge NRST_I)
	begin
		if (!NRST_I)
			hold_ack_reg <= 1'b0;
		else if (!NHOLD_I && !BUS_OE_O)
			hold_ack_reg <= 1'b1;
		else if (NHOLD_I)
			hold_ack_reg <= 1'b0;
	end

	// bus enable drops one cycle before acknowledge rises
	always_ff @(posedge SYS_CLK_I or negedge NRST_I)
	begin
		if (!NRST_I)
			BUS_OE_O <= 1'b0;
		else
			BUS_OE_O <= NHOLD_I && !hold_ack_reg;
	end
	assign NEXTERNAL_BUS_GRANT_ACK_O = !hold_ack_reg;

	// ------------------------------------------------------------
	// repeat
	// ------------------------------------------------------------
	always_ff @(posedge SYS_CLK_I or negedge NRST_I)
	begin
		if (!NRST_I)
		begin
			repeat_count_reg <= REPEAT_RESET;
			repeat_active_reg <= 1'b0;
		end
		else if (REPEAT_LOAD_I)
		begin
			repeat_count_reg <= REPEAT_VALUE_I;
			repeat_active_reg <= 1'b1;
		end
		else if (repeat_active_reg && INSTR_DONE_I)
		begin
			if (repeat_count_reg == 8'h00)
				repeat_active_reg <= 1'b0;
			else
				repeat_count_reg <= 8'(repeat_count_reg - 8'h01);
		end
	end
	assign REPEAT_ACTIVE_O = repeat_active_reg;
	assign SINGLE_CYCLE_REPEAT_O = repeat_active_reg && MULTICYCLE_I;

	// ------------------------------------------------------------
	// interrupts
	// ------------------------------------------------------------
	// timer zero raises the countdown event when mask bit IRQ_TIMER is set
	assign COUNTDOWN_INTERRUPT_O = timer_zero && interrupt_mask_reg[IRQ_TIMER];
	assign irq_live = pending_reg & interrupt_mask_reg[IRQ_COUNT-1:0];

	always_ff @(posedge SYS_CLK_I or negedge NRST_I)
	begin
		if (!NRST_I)
		begin
			pending_reg <= '0;
			ext_prev_reg <= 3'b111;
		end
		else
		begin
			ext_prev_reg <= NEXT_INTERRUPT_INPUTS_I;
			// set wins over acknowledge clear
			for (int i = 0; i < IRQ_COUNT; i++)
			begin
				if (IRQ_ACK_I && IRQ_TAKE_O && vector_next == 16'(VEC_FIRST_IRQ + (i << 1)))
					pending_reg[i] <= 1'b0;
				if ((i < 3 && ext_prev_reg[i] && !NEXT_INTERRUPT_INPUTS_I[i]) ||
					(i == IRQ_TIMER && timer_zero) || (i == IRQ_RX && RX_EVENT_I) ||
					(i == IRQ_TX && TX_EVENT_I))
					pending_reg[i] <= 1'b1;
			end
		end
	end

	always_comb
	begin
		vector_next = VEC_RESET;
		irq_any = 1'b0;
		for (int i = IRQ_COUNT - 1; i >= 0; i--)
		begin
			if (irq_live[i])
			begin
				vector_next = 16'(VEC_FIRST_IRQ + (i << VEC_STRIDE_SHIFT));
				irq_any = 1'b1;
			end
		end
		if (TRAP_I)
		begin
			vector_next = VEC_TRAP;
			irq_any = 1'b1;
		end
	end

	// hold off until instruction done, during repeat or wait states
	assign IRQ_TAKE_O = irq_any && INSTR_DONE_I && !repeat_active_reg &&
		!(ACC_REQ_I && !acc_done);
	always_ff @(posedge SYS_CLK_I or negedge NRST_I)
	begin
		if (!NRST_I)
			IRQ_VECTOR_O <= VEC_RESET;
		else
			IRQ_VECTOR_O <= vector_next;
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	property p_reload;
		@(posedge SYS_CLK_I) disable iff (!NRST_I)
		(timer_zero && !(acc_done && is_mapped && ACC_WRITE_I)) |=>
			countdown_value_reg == $past(reload_period_reg);
	endproperty
	a_reload: assert property (p_reload) else $error("timer did not reload");

	property p_hold;
		@(posedge SYS_CLK_I) disable iff (!NRST_I)
		!NHOLD_I && !hold_ack_reg |=> ##[0:2] !NEXTERNAL_BUS_GRANT_ACK_O && !BUS_OE_O;
	endproperty
	a_hold: assert property (p_hold) else $error("hold not acknowledged");

	property p_irq_hold;
		@(posedge SYS_CLK_I) disable iff (!NRST_I)
		repeat_active_reg |-> !IRQ_TAKE_O;
	endproperty
	a_irq_hold: assert property (p_irq_hold) else $error("interrupt during repeat");

	property p_map;
		@(posedge SYS_CLK_I) disable iff (!NRST_I)
		!BLOCK_IS_PROGRAM_O[2];
	endproperty
	a_map: assert property (p_map) else $error("fixed block mapped as program");

	property p_count_step;
		@(posedge SYS_CLK_I) disable iff (!NRST_I)
		(!timer_zero && !(acc_done && is_mapped && ACC_WRITE_I)) |=>
			countdown_value_reg == 16'($past(countdown_value_reg) - 16'h0001);
	endproperty
	a_count_step: assert property (p_count_step) else $error("timer missed a step");

	property p_stall;
		@(posedge SYS_CLK_I) disable iff (!NRST_I)
		(ACC_REQ_I && ACC_EXTERNAL_O && !READY_I) |-> !ACC_DONE_O;
	endproperty
	a_stall: assert property (p_stall) else $error("external access ended without ready");
endmodule

// ### ext_partner.sv
`timescale 1ns/1ns
module ext_partner
(
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic req_i,
	input wire logic external_i,
	input wire logic [3:0] wait_i,
	input wire logic hold_req_i,
	output logic ready_o,
	output logic nhold_o
);
	logic [3:0] cnt_reg;
	logic idle_reg;
	// ------------------------------
	// slow memory and second master
	// ------------------------------
	// ready held back
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			cnt_reg <= 4'h0;
		else if (!req_i)
			cnt_reg <= 4'h0;
		else if (external_i && cnt_reg != wait_i)
			cnt_reg <= cnt_reg + 4'h1;
	end
	// ready toggles outside a transfer so no stale level can pass for an answer
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			idle_reg <= 1'b0;
		else
			idle_reg <= ~idle_reg;
	end
	assign ready_o = (req_i && external_i) ? (cnt_reg == wait_i) : idle_reg;
	assign nhold_o = ~hold_req_i;
endmodule

// ### dsp_core_memory_and_control_tb.sv
`timescale 1ns/1ns
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin err_total++; \
	$display("FAIL %s exp %h got %h", nm, e, g); end end
module dsp_core_memory_and_control_tb
	import dsp_ctrl_pkg::*;
;
	logic SYS_CLK_I = 1'b0, NRST_I = 1'b0;
	logic MUL_LOAD_OPERAND_I, MUL_START_I, MUL_UNSIGNED_I, MUL_SET_SHIFT_I, MAP_SELECT_I;
	logic [15:0] MUL_OPERAND_I, MUL_DATA_I, ACC_WDATA_I, AUX_LOAD_DATA_I, RX_DATA_I;
	logic [1:0] MUL_SHIFT_I, MAP_CODE_I;
	logic ACC_REQ_I, ACC_WRITE_I, ACC_INDIRECT_I, AUX_LOAD_I, PAGE_LOAD_I, RX_DATA_LOAD_I;
	logic [6:0] ACC_OFFSET_I;
	logic [2:0] AUX_MODE_I, AUX_NEXT_PTR_I, NEXT_INTERRUPT_INPUTS_I;
	logic [8:0] PAGE_I;
	logic READY_I, NHOLD_I, REPEAT_LOAD_I, INSTR_DONE_I, MULTICYCLE_I;
	logic [7:0] REPEAT_VALUE_I;
	logic RX_EVENT_I, TX_EVENT_I, TRAP_I, IRQ_ACK_I;
	logic [31:0] PRODUCT_SHIFTED_O;
	logic [3:0] BLOCK_IS_PROGRAM_O;
	logic [15:0] ACC_RDATA_O, DATA_ADDR_O, TX_DATA_O, EXT_ADDR_O, IRQ_VECTOR_O;
	logic ACC_DONE_O, ACC_EXTERNAL_O, NSHARED_BUS_REQUEST_O, NEXTERNAL_BUS_GRANT_ACK_O, BUS_OE_O;
	logic REPEAT_ACTIVE_O, SINGLE_CYCLE_REPEAT_O, IRQ_TAKE_O, COUNTDOWN_INTERRUPT_O;
	int err_total = 0, compares = 0, acc_wait;
	logic hold_req = 1'b0, shared_seen;
	logic [3:0] wait_n = 4'h0;

	always #5 SYS_CLK_I = ~SYS_CLK_I;
	dsp_ctrl uut (.*);
	ext_partner far (.clk_i(SYS_CLK_I), .nrst_i(NRST_I), .req_i(ACC_REQ_I),
		.external_i(ACC_EXTERNAL_O), .wait_i(wait_n), .hold_req_i(hold_req),
		.ready_o(READY_I), .nhold_o(NHOLD_I));

	// --------------
	// bench helpers
	// --------------
	function automatic logic [31:0] prod(logic [15:0] a, logic [15:0] b, logic u, logic [1:0] m);
		logic signed [31:0] sa, sb, p;
		sa = u ? {16'h0000, a} : {{16{a[15]}}, a};
		sb = u ? {16'h0000, b} : {{16{b[15]}}, b};
		p = sa * sb;
		case (m)
			2'h0: return p;
			2'h1: return p <<< 1;
			2'h2: return p <<< 4;
			default: return p >>> 6;
		endcase
	endfunction
	function automatic logic [15:0] rev16(logic [15:0] x);
		logic [15:0] r;
		for (int k = 0; k < 16; k++)
			r[k] = x[15 - k];
		return r;
	endfunction
	function automatic logic [15:0] step(logic [15:0] c, aux_mode_t m);
		case (m)
			AUX_INC: return c + 16'h0001;
			AUX_DEC: return c - 16'h0001;
			AUX_ADD_IDX: return c + 16'h1234;
			AUX_SUB_IDX: return c - 16'h1234;
			AUX_REV_INC: return rev16(16'(rev16(c) + rev16(16'h1234)));
			AUX_REV_DEC: return rev16(16'(rev16(c) - rev16(16'h1234)));
			default: return c;
		endcase
	endfunction
	task tick();
		@(posedge SYS_CLK_I);
		#1;
	endtask
	// request held until done is seen high at a falling edge
	task acc(input logic w, input logic ind, input logic [6:0] off, input logic [15:0] wd,
		output logic [15:0] rd);
		// one idle edge so a back-to-back call never re-raises the request in one step
		tick();
		ACC_REQ_I = 1'b1;
		ACC_WRITE_I = w;
		ACC_INDIRECT_I = ind;
		ACC_OFFSET_I = off;
		ACC_WDATA_I = wd;
		acc_wait = 0;
		shared_seen = 1'b0;
		@(negedge SYS_CLK_I);
		while (ACC_DONE_O !== 1'b1 && acc_wait < 50)
		begin
			if (NSHARED_BUS_REQUEST_O === 1'b0)
				shared_seen = 1'b1;
			@(negedge SYS_CLK_I);
			acc_wait++;
		end
		if (NSHARED_BUS_REQUEST_O === 1'b0)
			shared_seen = 1'b1;
		tick();
		ACC_REQ_I = 1'b0;
		rd = ACC_RDATA_O;
	endtask
	task wr(input logic [6:0] off, input logic [15:0] d);
		logic [15:0] x;
		acc(1'b1, 1'b0, off, d, x);
	endtask
	task rchk(input string nm, input logic [6:0] off, input logic [15:0] e);
		logic [15:0] x;
		acc(1'b0, 1'b0, off, 16'h0000, x);
		`CHK(nm, e, x)
	endtask
	task setpage(input logic [8:0] p);
		PAGE_I = p;
		PAGE_LOAD_I = 1'b1;
		tick();
		PAGE_LOAD_I = 1'b0;
	endtask
	task irqw(input logic [15:0] e);
		int k;
		k = 0;
		while (IRQ_TAKE_O !== 1'b1 && k < 20)
		begin
			tick();
			k++;
		end
		`CHK("vector", e, IRQ_VECTOR_O)
		IRQ_ACK_I = 1'b1;
		tick();
		IRQ_ACK_I = 1'b0;
		tick();
	endtask
	task tally_and_finish();
		$display("compares %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	initial
	begin
		#200000;
		err_total++;
		$display("FAIL watchdog exp done got timeout");
		tally_and_finish();
	end

	// ----------
	// scenarios
	// ----------
	initial
	begin
		logic [15:0] a, b, d, rd, r1, cur;
		logic u;
		logic [7:0] v;
		int n;
		aux_mode_t ms[7];
		{MUL_LOAD_OPERAND_I, MUL_START_I, MUL_UNSIGNED_I, MUL_SET_SHIFT_I, MAP_SELECT_I} = '0;
		{MUL_OPERAND_I, MUL_DATA_I, ACC_WDATA_I, AUX_LOAD_DATA_I, RX_DATA_I} = '0;
		{MUL_SHIFT_I, MAP_CODE_I, ACC_OFFSET_I, AUX_MODE_I, AUX_NEXT_PTR_I, PAGE_I} = '0;
		{ACC_REQ_I, ACC_WRITE_I, ACC_INDIRECT_I, AUX_LOAD_I, PAGE_LOAD_I, RX_DATA_LOAD_I} = '0;
		{REPEAT_LOAD_I, INSTR_DONE_I, MULTICYCLE_I, REPEAT_VALUE_I} = '0;
		{RX_EVENT_I, TX_EVENT_I, TRAP_I, IRQ_ACK_I} = '0;
		NEXT_INTERRUPT_INPUTS_I = 3'h7;
		void'($urandom(32'hb5dc));
		repeat (10) @(posedge SYS_CLK_I);
		#1 NRST_I = 1'b1;
		`CHK("map_reset", 4'h0, BLOCK_IS_PROGRAM_O)
		rchk("period", 7'h03, PERIOD_RESET);
		rchk("mask", 7'h04, MASK_RESET);
		rchk("shared", 7'h05, {8'h00, SHARED_RESET});
		acc(1'b0, 1'b0, 7'h02, 16'h0000, r1);
		acc(1'b0, 1'b0, 7'h02, 16'h0000, rd);
		`CHK("count_step", r1 - 16'h0002, rd)
		for (int i = 0; i < 6; i++)
		begin
			d = 16'($urandom);
			wr(7'h04, d);
			rchk("mask_rw", 7'h04, d);
			wr(7'h05, d);
			acc(1'b0, 1'b0, 7'h05, 16'h0000, rd);
			`CHK("shared_rw", d[7:0], rd[7:0])
			wr(7'h01, d);
			`CHK("tx", d, TX_DATA_O)
			RX_DATA_I = ~d;
			RX_DATA_LOAD_I = 1'b1;
			tick();
			RX_DATA_LOAD_I = 1'b0;
			rchk("rx", 7'h00, ~d);
		end
		wr(7'h04, 16'h0000);
		for (int i = 0; i < 5; i++)
		begin
			MAP_SELECT_I = 1'b1;
			MAP_CODE_I = 2'(i % 4);
			tick();
			MAP_SELECT_I = 1'b0;
			`CHK("map", {i == 3, 1'b0, i == 2 || i == 3, i % 4 != 0}, BLOCK_IS_PROGRAM_O)
		end
		for (int i = 0; i < 16; i++)
		begin
			a = (i == 0) ? 16'h8000 : (i == 1) ? 16'hFFFF : 16'($urandom);
			b = (i == 0) ? 16'h8000 : (i == 1) ? 16'hFFFF : 16'($urandom);
			u = (i == 1) ? 1'b1 : (i == 5) ? 1'b0 : 1'($urandom);
			MUL_SET_SHIFT_I = 1'b1;
			MUL_SHIFT_I = 2'(i);
			MUL_LOAD_OPERAND_I = 1'b1;
			MUL_OPERAND_I = a;
			tick();
			{MUL_SET_SHIFT_I, MUL_LOAD_OPERAND_I} = 2'h0;
			MUL_START_I = 1'b1;
			MUL_DATA_I = b;
			MUL_UNSIGNED_I = u;
			tick();
			MUL_START_I = 1'b0;
			tick();
			`CHK("product", prod(a, b, u, 2'(i)), PRODUCT_SHIFTED_O)
		end
		wr(7'h05, 16'h0001);
		setpage(9'h1FF);
		for (int i = 0; i < 3; i++)
		begin
			wait_n = 4'(i * i + i);
			acc(1'b0, 1'b0, 7'h05, 16'h0000, rd);
			`CHK("ready_wait", i * i + i, acc_wait)
			`CHK("bus_request", 1'b1, shared_seen)
			`CHK("direct_addr", 16'hFF85, DATA_ADDR_O)
			tick();
		end
		wait_n = 4'h0;
		setpage(9'h0FE);
		acc(1'b0, 1'b0, 7'h05, 16'h0000, rd);
		`CHK("bus_request_out", 1'b0, shared_seen)
		setpage(9'h000);
		hold_req = 1'b1;
		tick();
		`CHK("oe_float", 1'b0, BUS_OE_O)
		`CHK("ack_after", 1'b1, NEXTERNAL_BUS_GRANT_ACK_O)
		tick();
		`CHK("ack", 1'b0, NEXTERNAL_BUS_GRANT_ACK_O)
		repeat (5) tick();
		`CHK("ack_stays", 1'b0, NEXTERNAL_BUS_GRANT_ACK_O)
		hold_req = 1'b0;
		tick();
		`CHK("ack_release", 1'b1, NEXTERNAL_BUS_GRANT_ACK_O)
		tick();
		`CHK("oe_back", 1'b1, BUS_OE_O)
		AUX_LOAD_I = 1'b1;
		AUX_LOAD_DATA_I = 16'h1234;
		tick();
		AUX_MODE_I = AUX_NONE;
		AUX_NEXT_PTR_I = 3'h2;
		AUX_LOAD_I = 1'b0;
		acc(1'b0, 1'b1, 7'h00, 16'h0000, rd);
		`CHK("ind_ar0", 16'h1234, DATA_ADDR_O)
		AUX_LOAD_I = 1'b1;
		AUX_LOAD_DATA_I = 16'h0010;
		tick();
		AUX_LOAD_I = 1'b0;
		cur = 16'h0010;
		ms = '{AUX_INC, AUX_DEC, AUX_ADD_IDX, AUX_SUB_IDX, AUX_NONE, AUX_REV_INC, AUX_REV_DEC};
		for (int i = 0; i < 7; i++)
		begin
			AUX_MODE_I = ms[i];
			acc(1'b0, 1'b1, 7'h00, 16'h0000, rd);
			`CHK("ind_addr", cur, DATA_ADDR_O)
			cur = step(cur, ms[i]);
		end
		AUX_MODE_I = AUX_NONE;
		for (int i = 0; i < 3; i++)
		begin
			v = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($urandom % 16);
			REPEAT_LOAD_I = 1'b1;
			REPEAT_VALUE_I = v;
			tick();
			REPEAT_LOAD_I = 1'b0;
			MULTICYCLE_I = 1'b1;
			#1;
			`CHK("repeat_on", 1'b1, REPEAT_ACTIVE_O)
			`CHK("pipelined", 1'b1, SINGLE_CYCLE_REPEAT_O)
			INSTR_DONE_I = 1'b1;
			n = 0;
			do
			begin
				tick();
				n++;
			end while (REPEAT_ACTIVE_O === 1'b1 && n < 300);
			{INSTR_DONE_I, MULTICYCLE_I} = 2'h0;
			`CHK("repeats", int'(v) + 1, n)
		end
		wr(7'h04, 16'h0007);
		MULTICYCLE_I = 1'b1;
		NEXT_INTERRUPT_INPUTS_I = 3'h5;
		repeat (4) tick();
		`CHK("irq_held", 1'b0, IRQ_TAKE_O)
		MULTICYCLE_I = 1'b0;
		INSTR_DONE_I = 1'b1;
		irqw(VEC_FIRST_IRQ + 16'(2 * IRQ_EXT1));
		NEXT_INTERRUPT_INPUTS_I = 3'h7;
		tick();
		NEXT_INTERRUPT_INPUTS_I = 3'h2;
		TRAP_I = 1'b1;
		tick();
		irqw(VEC_TRAP);
		TRAP_I = 1'b0;
		tick();
		irqw(VEC_FIRST_IRQ + 16'(2 * IRQ_EXT0));
		irqw(VEC_FIRST_IRQ + 16'(2 * IRQ_EXT2));
		INSTR_DONE_I = 1'b0;
		wr(7'h03, 16'h0005);
		wr(7'h02, 16'h0003);
		wr(7'h04, 16'h0000);
		n = 0;
		repeat (20)
		begin
			tick();
			n += int'(COUNTDOWN_INTERRUPT_O === 1'b1);
		end
		`CHK("countdown_interrupt_masked", 0, n)
		wr(7'h04, 16'h0008);
		n = 0;
		while (COUNTDOWN_INTERRUPT_O !== 1'b1 && n < 40)
		begin
			tick();
			n++;
		end
		n = 1;
		tick();
		while (COUNTDOWN_INTERRUPT_O !== 1'b1 && n < 40)
		begin
			tick();
			n++;
		end
		`CHK("countdown_interrupt_gap", 6, n)
		tally_and_finish();
	end
endmodule
